/* File: design/fsc_defines.vh */
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define FSC_IDX_USB_CONTROL     7'h13
`define FSC_IDX_CPU_MODE        7'h3b
`define FSC_IDX_SYNTH_CONTROL   7'h6c
`define FSC_IDX_SYNTH_MULTIPLY  7'h6d
`define FSC_IDX_SYNTH_PRESCALE  7'h6e
`define FSC_IDX_SYNTH_POSTSCALE 7'h6f

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FSC_CTL_ENABLE_BIT      0
`define FSC_CTL_INSEL_BIT       1
`define FSC_CTL_LF_LO           5
`define FSC_CTL_LF_HI           6
`define FSC_CTL_LOCK_BIT        7
`define FSC_MODE_SYSSEL_BIT     0
`define FSC_LF_RESET            2'h3
`define FSC_BYTE_RESET          8'h00
`define FSC_WORD_ZERO           32'h0000_0000

// ----------------------------------------------------------------
// Divider and lock constants
// ----------------------------------------------------------------
`define FSC_DIV_BYPASS          8'hff
`define FSC_LOCK_SETTLE_EDGES   8'h10
`define FSC_PERIOD_MAX          16'hffff

`endif

/* File: design/fsc_even_div.v */
`timescale 1ns/10ps
`include "fsc_defines.vh"

// ----------------------------------------------------------------
// Even divider: divides by 2(n+1), passes through at bypass code
// ----------------------------------------------------------------
module fsc_even_div (
   input  wire       clk_i,      // System clock
   input  wire       rstn_i,     // Async reset, active low
   input  wire       run_i,      // Divider running
   input  wire       src_lvl_i,  // Source clock level
   input  wire       src_rise_i, // Source rising edge pulse
   input  wire [7:0] div_val_i,  // Divide setting n
   output reg        out_lvl_o,  // Divided clock level
   output reg        out_rise_o  // Divided rising edge pulse
);

   reg [7:0] cnt_q;

   // Toggle every n+1 source edges, so one period is 2(n+1) edges
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_q      <= `FSC_BYTE_RESET;
         out_lvl_o  <= 1'b0;
         out_rise_o <= 1'b0;
      end
      else if (!run_i)
      begin
         cnt_q      <= `FSC_BYTE_RESET;
         out_rise_o <= 1'b0;
      end
      else if (div_val_i == `FSC_DIV_BYPASS)
      begin
         cnt_q      <= `FSC_BYTE_RESET;
         out_lvl_o  <= src_lvl_i;
         out_rise_o <= src_rise_i;
      end
      else if (src_rise_i)
      begin
         if (cnt_q >= div_val_i)
         begin
            cnt_q      <= `FSC_BYTE_RESET;
            out_lvl_o  <= ~out_lvl_o;
            out_rise_o <= ~out_lvl_o;
         end
         else
         begin
            cnt_q      <= cnt_q + 8'h01;
            out_rise_o <= 1'b0;
         end
      end
      else
      begin
         out_rise_o <= 1'b0;
      end
   end

endmodule // fsc_even_div

/* File: design/fsc_nco.v */
`timescale 1ns/10ps
`include "fsc_defines.vh"

// ----------------------------------------------------------------
// Multiplier model: measures the reference period, then an
// accumulator toggles the output 4(n+1) times per reference period
// ----------------------------------------------------------------
module fsc_nco (
   input  wire       clk_i,      // System clock
   input  wire       rstn_i,     // Async reset, active low
   input  wire       run_i,      // Oscillator running
   input  wire       ref_rise_i, // Phase reference rising edge
   input  wire [7:0] mul_val_i,  // Multiply setting n
   output reg        vco_lvl_o,  // Oscillator level
   output reg        vco_rise_o, // Oscillator rising edge pulse
   output reg        stable_o    // Last two periods agree
);

   reg  [15:0] cnt_q;
   reg  [15:0] period_q;
   reg  [15:0] acc_q;
   wire [15:0] step;
   wire [15:0] cnt_inc;
   wire [15:0] acc_sum;

   assign step    = {6'h00, mul_val_i, 2'b00} + 16'h0004;
   assign cnt_inc = cnt_q + 16'h0001;
   assign acc_sum = acc_q + step;

   // Period measured in system cycles, one cycle of jitter allowed
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_q    <= 16'h0000;
         period_q <= 16'h0000;
         stable_o <= 1'b0;
      end
      else if (!run_i)
      begin
         cnt_q    <= 16'h0000;
         period_q <= 16'h0000;
         stable_o <= 1'b0;
      end
      else if (ref_rise_i)
      begin
         cnt_q    <= 16'h0000;
         period_q <= cnt_inc;
         stable_o <= (cnt_inc == period_q) || (cnt_q == period_q) ||
                     ((cnt_inc + 16'h0001) == period_q);
      end
      else if (cnt_q != `FSC_PERIOD_MAX)
      begin
         cnt_q <= cnt_inc;
      end
   end

   // Output stops at its current level while not running
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         acc_q      <= 16'h0000;
         vco_lvl_o  <= 1'b0;
         vco_rise_o <= 1'b0;
      end
      else if (!run_i || (period_q == 16'h0000))
      begin
         acc_q      <= 16'h0000;
         vco_rise_o <= 1'b0;
      end
      else if (acc_sum >= period_q)
      begin
         acc_q      <= acc_sum - period_q;
         vco_lvl_o  <= ~vco_lvl_o;
         vco_rise_o <= ~vco_lvl_o;
      end
      else
      begin
         acc_q      <= acc_sum;
         vco_rise_o <= 1'b0;
      end
   end

endmodule // fsc_nco

/* File: design/fsc_synth_ctrl.v */
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "fsc_defines.vh"

module fsc_synth_ctrl (
   input  wire        sys_clk_i,         // System clock, 50 MHz
   input  wire        rstn_i,            // Async reset, active low
   input  wire [8:0]  avs_address_i,     // Avalon byte address
   input  wire        avs_read_i,        // Avalon read strobe
   input  wire        avs_write_i,       // Avalon write strobe
   input  wire [31:0] avs_writedata_i,   // Avalon write data
   input  wire [3:0]  avs_byteenable_i,  // Avalon byte enables
   output reg  [31:0] avs_readdata_o,    // Avalon read data
   output reg         avs_waitrequest_o, // Avalon wait request
   input  wire        main_osc_i,        // Main reference clock level
   input  wire        sub_osc_i,         // Sub reference clock level
   output reg         usb_clk_o,         // Oscillator output, USB clock
   output reg         syn_clk_o,         // Synthesized clock
   output reg         syn_valid_o,       // Synthesized clock usable
   output reg         sys_clk_sel_o,     // Use synthesized system clock
   output reg         lock_o,            // Lock status
   output reg  [1:0]  loop_filter_o,     // Loop filter current bits
   output reg  [7:0]  usb_control_o      // USB control register
);

   // ----------------------------------------------------------------
   // Lock tracker states
   // ----------------------------------------------------------------
   localparam [3:0] ST_OFF    = 4'b0001;
   localparam [3:0] ST_MEAS   = 4'b0010;
   localparam [3:0] ST_SETTLE = 4'b0100;
   localparam [3:0] ST_LOCK   = 4'b1000;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg  [7:0]  usb_ctl_q;
   reg         enable_q;
   reg         insel_q;
   reg  [1:0]  lf_q;
   reg  [7:0]  mul_q;
   reg  [7:0]  pre_q;
   reg  [7:0]  post_q;
   reg         syssel_q;
   reg         cfg_chg_q;
   reg         src_prev_q;
   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg  [7:0]  settle_q;
   reg  [7:0]  settle_d;
   reg  [31:0] rdata_d;
   wire [6:0]  reg_idx;
   wire        req;
   wire        wr_go;
   wire        src_lvl;
   wire        fin_rise;
   wire        pin_lvl;
   wire        pin_rise;
   wire        vco_lvl;
   wire        vco_rise;
   wire        vco_stable;
   wire        syn_lvl;
   wire        post_bypass;
   wire        locked;
   wire [7:0]  ctl_rd;
   wire [7:0]  wbyte;

   assign reg_idx     = avs_address_i[8:2];
   assign req         = avs_read_i | avs_write_i;
   assign wr_go       = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
   assign wbyte       = avs_writedata_i[7:0];
   assign post_bypass = (post_q == `FSC_DIV_BYPASS);
   assign locked      = (state_q == ST_LOCK);

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // One wait state: read data is registered on the same edge that waitrequest
   // drops, so it already stands at the edge the master samples it
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= `FSC_WORD_ZERO;
      end
      else if (req && avs_waitrequest_o)
      begin
         avs_waitrequest_o <= 1'b0;
         avs_readdata_o    <= rdata_d;
      end
      else
      begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // Control byte as software sees it, lock bit read-only
   assign ctl_rd = {locked, lf_q, 3'b000, insel_q, enable_q};

   // Read decode; unmapped indices read as zero
   always @*
   begin
      rdata_d = `FSC_WORD_ZERO;
      case (reg_idx)
         `FSC_IDX_USB_CONTROL:     rdata_d = {24'h000000, usb_ctl_q};
         `FSC_IDX_CPU_MODE:        rdata_d = {31'h00000000, syssel_q};
         `FSC_IDX_SYNTH_CONTROL:   rdata_d = {24'h000000, ctl_rd};
         `FSC_IDX_SYNTH_MULTIPLY:  rdata_d = {24'h000000, mul_q};
         `FSC_IDX_SYNTH_PRESCALE:  rdata_d = {24'h000000, pre_q};
         `FSC_IDX_SYNTH_POSTSCALE: rdata_d = {24'h000000, post_q};
         default:                  rdata_d = `FSC_WORD_ZERO;
      endcase
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Writes land on the edge where waitrequest is seen low
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         usb_ctl_q <= `FSC_BYTE_RESET;
         enable_q  <= 1'b0;
         insel_q   <= 1'b0;
         lf_q      <= `FSC_LF_RESET;
         mul_q     <= `FSC_BYTE_RESET;
         pre_q     <= `FSC_BYTE_RESET;
         post_q    <= `FSC_BYTE_RESET;
         syssel_q  <= 1'b0;
      end
      else if (wr_go)
      begin
         case (reg_idx)
            `FSC_IDX_USB_CONTROL:
            begin
               usb_ctl_q <= wbyte;
            end
            `FSC_IDX_CPU_MODE:
            begin
               syssel_q <= wbyte[`FSC_MODE_SYSSEL_BIT];
            end
            `FSC_IDX_SYNTH_CONTROL:
            begin
               enable_q <= wbyte[`FSC_CTL_ENABLE_BIT];
               insel_q  <= wbyte[`FSC_CTL_INSEL_BIT];
               lf_q     <= wbyte[`FSC_CTL_LF_HI:`FSC_CTL_LF_LO];
            end
            `FSC_IDX_SYNTH_MULTIPLY:
            begin
               mul_q <= wbyte;
            end
            `FSC_IDX_SYNTH_PRESCALE:
            begin
               pre_q <= wbyte;
            end
            `FSC_IDX_SYNTH_POSTSCALE:
            begin
               post_q <= wbyte;
            end
            default:
            begin
               usb_ctl_q <= usb_ctl_q;
            end
         endcase
      end
   end

   // Any write that retunes the loop throws away the lock
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cfg_chg_q <= 1'b0;
      end
      else
      begin
         cfg_chg_q <= wr_go && ((reg_idx == `FSC_IDX_SYNTH_MULTIPLY) ||
                      (reg_idx == `FSC_IDX_SYNTH_PRESCALE) ||
                      (reg_idx == `FSC_IDX_SYNTH_POSTSCALE) ||
                      ((reg_idx == `FSC_IDX_SYNTH_CONTROL) &&
                       (wbyte[`FSC_CTL_INSEL_BIT] != insel_q)));
      end
   end

   // ----------------------------------------------------------------
   // Reference selection and edge detection
   // ----------------------------------------------------------------
   // Inputs are synchronous, so a plain previous-level flop suffices
   assign src_lvl  = insel_q ? sub_osc_i : main_osc_i;
   assign fin_rise = src_lvl & ~src_prev_q;

   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         src_prev_q <= 1'b0;
      end
      else
      begin
         src_prev_q <= src_lvl;
      end
   end

   // ----------------------------------------------------------------
   // Clock chain: pre-divider, multiplier, post-divider
   // ----------------------------------------------------------------
   // Pre-divider, with bypass at the all-ones setting
   fsc_even_div u_pre_div (
      .clk_i      (sys_clk_i),
      .rstn_i     (rstn_i),
      .run_i      (enable_q),
      .src_lvl_i  (src_lvl),
      .src_rise_i (fin_rise),
      .div_val_i  (pre_q),
      .out_lvl_o  (pin_lvl),
      .out_rise_o (pin_rise)
   );

   // Oscillator model; it freezes its level when disabled
   fsc_nco u_nco (
      .clk_i      (sys_clk_i),
      .rstn_i     (rstn_i),
      .run_i      (enable_q),
      .ref_rise_i (pin_rise),
      .mul_val_i  (mul_q),
      .vco_lvl_o  (vco_lvl),
      .vco_rise_o (vco_rise),
      .stable_o   (vco_stable)
   );

   // Post-divider; the bypass code marks the output invalid instead
   fsc_even_div u_post_div (
      .clk_i      (sys_clk_i),
      .rstn_i     (rstn_i),
      .run_i      (enable_q),
      .src_lvl_i  (vco_lvl),
      .src_rise_i (vco_rise),
      .div_val_i  (post_q),
      .out_lvl_o  (syn_lvl),
      .out_rise_o ()
   );

   // ----------------------------------------------------------------
   // Lock tracker
   // ----------------------------------------------------------------
   // Lock needs a run of steady reference periods; a single odd
   // period drops back to measuring rather than to off
   always @*
   begin
      state_d  = state_q;
      settle_d = settle_q;
      case (state_q)
         ST_OFF:
         begin
            settle_d = `FSC_BYTE_RESET;
            if (enable_q)
               state_d = ST_MEAS;
         end
         ST_MEAS:
         begin
            settle_d = `FSC_BYTE_RESET;
            if (pin_rise && vco_stable)
               state_d = ST_SETTLE;
         end
         ST_SETTLE:
         begin
            if (pin_rise && !vco_stable)
            begin
               state_d = ST_MEAS;
            end
            else if (pin_rise)
            begin
               if (settle_q == (`FSC_LOCK_SETTLE_EDGES - 8'h01))
                  state_d = ST_LOCK;
               else
                  settle_d = settle_q + 8'h01;
            end
         end
         ST_LOCK:
         begin
            if (pin_rise && !vco_stable)
               state_d = ST_MEAS;
         end
         default:
         begin
            state_d  = ST_OFF;
            settle_d = `FSC_BYTE_RESET;
         end
      endcase
      if (!enable_q || cfg_chg_q)
      begin
         state_d  = ST_OFF;
         settle_d = `FSC_BYTE_RESET;
      end
   end

   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_q  <= ST_OFF;
         settle_q <= `FSC_BYTE_RESET;
      end
      else
      begin
         state_q  <= state_d;
         settle_q <= settle_d;
      end
   end

   // ----------------------------------------------------------------
   // Output stage
   // ----------------------------------------------------------------
   // Every output is a flop; system clock switch-over only happens
   // once the synthesized clock is valid and locked, to avoid glitches
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         usb_clk_o     <= 1'b0;
         syn_clk_o     <= 1'b0;
         syn_valid_o   <= 1'b0;
         sys_clk_sel_o <= 1'b0;
         lock_o        <= 1'b0;
         loop_filter_o <= `FSC_LF_RESET;
         usb_control_o <= `FSC_BYTE_RESET;
      end
      else
      begin
         usb_clk_o     <= vco_lvl;
         syn_clk_o     <= syn_lvl & ~post_bypass;
         syn_valid_o   <= enable_q & ~post_bypass;
         sys_clk_sel_o <= syssel_q & locked & ~post_bypass;
         lock_o        <= locked;
         loop_filter_o <= lf_q;
         usb_control_o <= usb_ctl_q;
      end
   end

endmodule // fsc_synth_ctrl

/* File: tb/fsc_synth_ctrl_chk.sv */
`timescale 1ns/10ps
// ------------------------------------------------
// Bus shadow and port checks
// ------------------------------------------------
module fsc_synth_ctrl_chk (
   input logic        sys_clk_i,         // System clock
   input logic        rstn_i,            // Reset, active low
   input logic [8:0]  avs_address_i,     // Byte address
   input logic        avs_read_i,        // Read strobe
   input logic        avs_write_i,       // Write strobe
   input logic [31:0] avs_writedata_i,   // Write data
   input logic [3:0]  avs_byteenable_i,  // Byte enables
   input logic [31:0] avs_readdata_o,    // Read data
   input logic        avs_waitrequest_o, // Wait request
   input logic        usb_clk_o,         // Oscillator output
   input logic        syn_clk_o,         // Synthesized clock
   input logic        syn_valid_o,       // Synthesized clock usable
   input logic        sys_clk_sel_o,     // System clock switch
   input logic        lock_o,            // Lock status
   input logic [1:0]  loop_filter_o      // Loop filter bits
);
   wire        wr_ok = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
   wire  [6:0] idx   = avs_address_i[8:2];
   logic       en_q;
   logic       mode_q;
   logic [7:0] post_q;
   logic [1:0] lf_q;
   logic [3:0] chg_q;
   logic [3:0] dis_q;

   // Shadow state; any write with byte lane 0 enabled restarts the settle count
   always @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         en_q   <= 1'b0;
         mode_q <= 1'b0;
         post_q <= 8'h00;
         lf_q   <= 2'h3;
         chg_q  <= 4'h0;
         dis_q  <= 4'h0;
      end
      else
      begin
         chg_q <= wr_ok ? 4'h0 : (chg_q == 4'hf ? chg_q : chg_q + 4'h1);
         dis_q <= en_q ? 4'h0 : (dis_q == 4'hf ? dis_q : dis_q + 4'h1);
         if (wr_ok && idx == 7'h6c)
         begin
            en_q <= avs_writedata_i[0];
            lf_q <= avs_writedata_i[6:5];
         end
         if (wr_ok && idx == 7'h6f)
            post_q <= avs_writedata_i[7:0];
         if (wr_ok && idx == 7'h3b)
            mode_q <= avs_writedata_i[0];
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("waitrequest not low after request");
   a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_rd_upper: assert property (avs_read_i && !avs_waitrequest_o
      |-> avs_readdata_o[31:8] == 24'h000000) else $error("read data upper bits set");
   a_lf_reset: assert property ($rose(rstn_i) |-> loop_filter_o == 2'b11)
      else $error("loop filter reset value wrong");
   a_lf_mirror: assert property (chg_q >= 4'h3 |-> loop_filter_o == lf_q)
      else $error("loop filter output differs from register");
   a_usb_static: assert property (dis_q >= 4'h3 |-> $stable(usb_clk_o))
      else $error("oscillator toggles while disabled");
   a_lock_off: assert property (dis_q >= 4'h3 |-> !lock_o)
      else $error("lock while disabled");
   a_chg_unlock: assert property (wr_ok && idx >= 7'h6d && idx <= 7'h6f
      |-> ##[1:4] !lock_o) else $error("lock kept after divider write");
   a_valid_map: assert property (chg_q >= 4'h3
      |-> syn_valid_o == (en_q && post_q != 8'hff)) else $error("valid flag wrong");
   a_no_div_out: assert property (chg_q >= 4'h3 && post_q == 8'hff |-> !syn_clk_o)
      else $error("synthesized clock runs at bypass code");
   a_sel_gate: assert property (chg_q >= 4'h3 && sys_clk_sel_o
      |-> mode_q && post_q != 8'hff) else $error("clock switch without mode bit");

   c_lock: cover property ($rose(lock_o));
   c_sel: cover property (sys_clk_sel_o);
   c_bypass: cover property (en_q && post_q == 8'hff && lock_o);
endmodule // fsc_synth_ctrl_chk

/* File: tb/fsc_synth_ctrl_tb_top.sv */
`timescale 1ns/10ps
`include "fsc_defines.vh"

module fsc_synth_ctrl_tb_top;
   // ------------------------------------------------
   // Signals and row table
   // ------------------------------------------------
   typedef struct {logic sel; logic [7:0] pre, mul, post; int up;} fsc_row_t;
   localparam int W = 960; // Window; multiple of every period used
   localparam logic [6:0] ix_ctl = `FSC_IDX_SYNTH_CONTROL;
   logic        sys_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [8:0]  avs_address_i = 9'h000;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic [3:0]  avs_byteenable_i = 4'hf;
   logic        main_osc_i = 1'b0;
   logic        sub_osc_i = 1'b0;
   wire  [31:0] avs_readdata_o;
   wire         avs_waitrequest_o, usb_clk_o, syn_clk_o, syn_valid_o, sys_clk_sel_o, lock_o;
   wire  [1:0]  loop_filter_o;
   wire  [7:0]  usb_control_o;
   int          err_count = 0;
   int          n_tests = 0;
   int          osc_cnt = 0;
   fsc_row_t    rows [5] = '{'{1'b0, 8'h00, 8'h01, 8'h00, 4}, '{1'b0, 8'hff, 8'h01, 8'h01, 2},
                             '{1'b1, 8'h00, 8'h02, 8'h02, 4}, '{1'b1, 8'h01, 8'h03, 8'hff, 6},
                             '{1'b0, 8'h02, 8'h05, 8'h00, 4}};

   // 50 MHz system clock
   initial
   begin
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   // References: main period 8 cycles, sub period 12, so select shows in rates
   always @(posedge sys_clk_i)
   begin
      osc_cnt    <= (osc_cnt == 23) ? 0 : osc_cnt + 1;
      main_osc_i <= (osc_cnt % 8) < 4;
      sub_osc_i  <= (osc_cnt % 12) < 6;
   end

   fsc_synth_ctrl dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .main_osc_i(main_osc_i), .sub_osc_i(sub_osc_i), .usb_clk_o(usb_clk_o),
      .syn_clk_o(syn_clk_o), .syn_valid_o(syn_valid_o), .sys_clk_sel_o(sys_clk_sel_o),
      .lock_o(lock_o), .loop_filter_o(loop_filter_o), .usb_control_o(usb_control_o));

   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   task automatic end_sim();
      begin
         $display("Checks %0d, mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   // Tolerance only for edge counts, where window phase shifts one edge
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp,
                      input int tol);
      begin
         n_tests++;
         if ((tol == 0) ? (seen !== exp)
             : ((^seen === 1'bx) || seen > exp + tol || seen + tol < exp))
         begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
         end
      end
   endtask

   // One Avalon access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] wd,
                      input logic [3:0] be, output logic [7:0] rd);
      int n;
      begin
         n = 0;
         @(posedge sys_clk_i);
         avs_address_i    <= {idx, 2'b00};
         avs_write_i      <= w;
         avs_read_i       <= ~w;
         avs_writedata_i  <= {24'h000000, wd};
         avs_byteenable_i <= be;
         @(posedge sys_clk_i);
         while (avs_waitrequest_o !== 1'b0 && n < 40)
         begin
            @(posedge sys_clk_i);
            n++;
         end
         rd = avs_readdata_o[7:0];
         avs_write_i <= 1'b0;
         avs_read_i  <= 1'b0;
         if (n == 40)
         begin
            err_count++;
            $display("[ERR] bus answer expected 0 seen timeout");
            end_sim();
         end
      end
   endtask

   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      logic [7:0] v;
      bus(1'b1, idx, d, 4'hf, v);
   endtask

   task automatic rd_chk(input string nm, input logic [6:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      begin
         bus(1'b0, idx, 8'h00, 4'hf, v);
         chk(nm, v, exp, 0);
      end
   endtask

   // Program, enable, then poll the lock bit
   task automatic cfg_lock(input fsc_row_t r);
      logic [7:0] v;
      int k;
      begin
         wr(`FSC_IDX_CPU_MODE, 8'h01);
         wr(`FSC_IDX_SYNTH_PRESCALE, r.pre);
         wr(`FSC_IDX_SYNTH_MULTIPLY, r.mul);
         wr(`FSC_IDX_SYNTH_POSTSCALE, r.post);
         wr(ix_ctl, {6'b011000, r.sel, 1'b1});
         repeat (200) @(posedge sys_clk_i);
         v = 8'h00;
         k = 0;
         while (v[7] !== 1'b1 && k < 60)
         begin
            repeat (40) @(posedge sys_clk_i);
            bus(1'b0, ix_ctl, 8'h00, 4'hf, v);
            k++;
         end
         chk("lock_bit", v[7], 1'b1, 0);
         if (v[7] !== 1'b1) end_sim();
      end
   endtask

   task automatic measure(output int nu, output int ns);
      logic pu, ps;
      begin
         nu = 0;
         ns = 0;
         pu = usb_clk_o;
         ps = syn_clk_o;
         repeat (W)
         begin
            @(posedge sys_clk_i);
            nu += (usb_clk_o & ~pu);
            ns += (syn_clk_o & ~ps);
            pu = usb_clk_o;
            ps = syn_clk_o;
         end
      end
   endtask

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial
   begin
      logic [7:0] v;
      int nu, ns;
      fsc_row_t r;
      repeat (8) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      chk("lf_out_rst", loop_filter_o, 2'b11, 0);
      chk("usbc_out_rst", usb_control_o, 8'h00, 0);
      rd_chk("ctl_rst", ix_ctl, 8'h60);
      rd_chk("mul_rst", `FSC_IDX_SYNTH_MULTIPLY, 8'h00);
      rd_chk("pre_rst", `FSC_IDX_SYNTH_PRESCALE, 8'h00);
      rd_chk("post_rst", `FSC_IDX_SYNTH_POSTSCALE, 8'h00);
      rd_chk("mode_rst", `FSC_IDX_CPU_MODE, 8'h00);
      wr(7'h50, 8'h5a);
      rd_chk("usb_range", 7'h50, 8'h00);
      wr(ix_ctl, 8'he0);
      rd_chk("lock_ro", ix_ctl, 8'h60);
      bus(1'b1, `FSC_IDX_USB_CONTROL, 8'h5a, 4'he, v);
      rd_chk("be_ignored", `FSC_IDX_USB_CONTROL, 8'h00);
      wr(`FSC_IDX_USB_CONTROL, 8'ha5);
      rd_chk("usbc_rw", `FSC_IDX_USB_CONTROL, 8'ha5);
      chk("usbc_out", usb_control_o, 8'ha5, 0);
      foreach (rows[i])
      begin
         r = rows[i];
         cfg_lock(r);
         chk("lock_out", lock_o, 1'b1, 0);
         wr(ix_ctl, {6'b010000, r.sel, 1'b1});
         rd_chk("ctl_locked", ix_ctl, {6'b110000, r.sel, 1'b1});
         chk("lf_out", loop_filter_o, 2'b10, 0);
         chk("syn_valid", syn_valid_o, r.post != 8'hff, 0);
         chk("sys_sel", sys_clk_sel_o, r.post != 8'hff, 0);
         measure(nu, ns);
         chk("usb_rises", nu, W / r.up, 2);
         chk("syn_rises", ns, (r.post == 8'hff) ? 0 : W / (r.up * 2 * (r.post + 1)),
             (r.post == 8'hff) ? 0 : 2);
         wr(`FSC_IDX_SYNTH_POSTSCALE, r.post);
         repeat (4) @(posedge sys_clk_i);
         chk("lock_chg", lock_o, 1'b0, 0);
         wr(ix_ctl, {6'b010000, r.sel, 1'b0});
         repeat (4) @(posedge sys_clk_i);
         measure(nu, ns);
         chk("usb_frozen", nu, 0, 0);
         chk("lock_off", lock_o, 1'b0, 0);
         chk("valid_off", syn_valid_o, 1'b0, 0);
      end
      cfg_lock(rows[0]);
      @(posedge sys_clk_i);
      rstn_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk("lock_in_rst", lock_o, 1'b0, 0);
      rstn_i <= 1'b1;
      @(posedge sys_clk_i);
      chk("lf_rerst", loop_filter_o, 2'b11, 0);
      rd_chk("ctl_rerst", ix_ctl, 8'h60);
      end_sim();
   end
endmodule // fsc_synth_ctrl_tb_top

bind fsc_synth_ctrl fsc_synth_ctrl_chk chk_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .usb_clk_o(usb_clk_o), .syn_clk_o(syn_clk_o), .syn_valid_o(syn_valid_o),
   .sys_clk_sel_o(sys_clk_sel_o), .lock_o(lock_o), .loop_filter_o(loop_filter_o));
